/* sps_pkg.sv */
// shared types and constants for the string primitive sequencer
package sps_pkg;
   typedef enum logic [2:0] {
      SPS_OP_MOVE,
      SPS_OP_COMPARE,
      SPS_OP_SCAN,
      SPS_OP_LOAD,
      SPS_OP_STORE
   } sps_op_t;

   // prefix byte values, arbitrary neutral encodings
   localparam logic [7:0] SPS_PFX_WHILE_EQUAL = 8'hf3;
   localparam logic [7:0] SPS_PFX_WHILE_UNEQUAL = 8'hf2;
   localparam logic [7:0] SPS_PFX_NONE = 8'h00;
   localparam logic [15:0] SPS_STEP_BYTE = 16'h0001;
   localparam logic [15:0] SPS_STEP_WORD = 16'h0002;
   localparam logic [15:0] SPS_RESET_WORD = 16'h0000;
   localparam logic [5:0] SPS_FLAGS_RESET = 6'h00;
   localparam int SPS_BUF_DEPTH = 2;

   // arithmetic flags posted by compare and scan
   typedef struct packed {
      logic auxiliary_carry_flag;
      logic carry_flag;
      logic overflow_flag;
      logic parity_flag;
      logic sign_flag;
      logic zero_flag;
   } sps_flags_t;

   // one memory request toward the bus interface
   typedef struct packed {
      logic write;
      logic use_extra_seg;
      logic seg_override;
      logic word;
      logic [15:0] offset;
      logic [15:0] wdata;
   } sps_mem_req_t;
endpackage : sps_pkg

/* sps_buf.sv */
// two-entry valid/ready buffer for memory requests
`timescale 1ns/1ps
module sps_buf (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire sps_pkg::sps_mem_req_t i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output sps_pkg::sps_mem_req_t o_out_data
);
   sps_pkg::sps_mem_req_t mem_r [sps_pkg::SPS_BUF_DEPTH];
   logic wptr_r;
   logic rptr_r;
   logic [1:0] cnt_r;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;

   assign o_in_ready = (cnt_r != 2'h2);
   assign o_out_valid = (cnt_r != 2'h0);
   assign o_out_data = mem_r[rptr_r];

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         wptr_r <= 1'b0;
         rptr_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) begin
            mem_r[wptr_r] <= i_in_data;
            wptr_r <= ~wptr_r;
         end
         if (pop) rptr_r <= ~rptr_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : sps_buf

/* sps_sequencer.sv */
// string primitive sequencer with repeat prefix control
`timescale 1ns/1ps
module sps_sequencer (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic [7:0] i_prefix,
   input wire sps_pkg::sps_op_t i_op,
   input wire logic i_word,
   input wire logic i_seg_override,
   input wire logic i_direction_flag,
   input wire logic [15:0] i_src_index,
   input wire logic [15:0] i_dest_index,
   input wire logic [15:0] i_repeat_count,
   input wire logic [15:0] i_accumulator,
   input wire sps_pkg::sps_flags_t i_flags,
   input wire logic i_intr_pending,
   input wire logic i_nmi_pending,
   output logic o_busy,
   output logic o_done,
   output logic o_intr_break,
   output logic [7:0] o_resume_prefix,
   output logic [15:0] o_src_index,
   output logic [15:0] o_dest_index,
   output logic [15:0] o_repeat_count,
   output logic [15:0] o_accumulator,
   output sps_pkg::sps_flags_t o_flags,
   output logic o_mem_valid,
   input wire logic i_mem_ready,
   output sps_pkg::sps_mem_req_t o_mem_req,
   input wire logic i_rd_valid,
   input wire logic [15:0] i_rd_data
);
   typedef enum logic [2:0] {
      SPS_IDLE,
      SPS_CHECK,
      SPS_RD_SRC,
      SPS_RD_DST,
      SPS_WAIT_RD,
      SPS_WRITE,
      SPS_NEXT
   } sps_state_t;

   sps_state_t state_r;
   sps_state_t state_nxt;
   logic [7:0] prefix_r;
   sps_pkg::sps_op_t op_r;
   logic word_r;
   logic ovr_r;
   logic dir_r;
   logic [15:0] si_r;
   logic [15:0] di_r;
   logic [15:0] cnt_r;
   logic [15:0] acc_r;
   logic [15:0] src_val_r;
   logic waiting_dst_r;
   sps_pkg::sps_flags_t flags_r;
   logic done_r;
   logic brk_r;
   logic first_r;

   logic buf_in_valid;
   logic buf_in_ready;
   sps_pkg::sps_mem_req_t buf_in_data;

   wire iterate_prefix = (prefix_r == sps_pkg::SPS_PFX_WHILE_EQUAL) ||
              (prefix_r == sps_pkg::SPS_PFX_WHILE_UNEQUAL);
   wire rep_ne = (prefix_r == sps_pkg::SPS_PFX_WHILE_UNEQUAL);
   wire cond_op = (op_r == sps_pkg::SPS_OP_COMPARE) || (op_r == sps_pkg::SPS_OP_SCAN);
   wire uses_src = (op_r == sps_pkg::SPS_OP_MOVE) || (op_r == sps_pkg::SPS_OP_COMPARE) ||
                   (op_r == sps_pkg::SPS_OP_LOAD);
   wire uses_dst = (op_r != sps_pkg::SPS_OP_LOAD);
   wire reads_dst = (op_r == sps_pkg::SPS_OP_COMPARE) || (op_r == sps_pkg::SPS_OP_SCAN);
   wire [15:0] step = word_r ? sps_pkg::SPS_STEP_WORD : sps_pkg::SPS_STEP_BYTE;
   wire [15:0] si_step = dir_r ? 16'(si_r - step) : 16'(si_r + step);
   wire [15:0] di_step = dir_r ? 16'(di_r - step) : 16'(di_r + step);
   wire [15:0] cnt_dec = 16'(cnt_r - 16'h0001);

   // subtraction for compare and scan
   wire [15:0] minuend = (op_r == sps_pkg::SPS_OP_SCAN) ? acc_r : src_val_r;
   wire [16:0] diff = {1'b0, minuend} - {1'b0, i_rd_data};
   wire [4:0] nib = {1'b0, minuend[3:0]} - {1'b0, i_rd_data[3:0]};
   wire msb_a = word_r ? minuend[15] : minuend[7];
   wire msb_b = word_r ? i_rd_data[15] : i_rd_data[7];
   wire msb_r = word_r ? diff[15] : diff[7];
   wire borrow = word_r ? diff[16] : (minuend[7:0] < i_rd_data[7:0]);
   wire is_zero = word_r ? (diff[15:0] == 16'h0000) : (diff[7:0] == 8'h00);
   sps_pkg::sps_flags_t arith_flags;
   // one driver for the whole struct keeps lint quiet
   assign arith_flags = '{auxiliary_carry_flag: nib[4],
                          carry_flag: borrow,
                          overflow_flag: (msb_a != msb_b) && (msb_r != msb_a),
                          parity_flag: ~^diff[7:0],
                          sign_flag: msb_r,
                          zero_flag: is_zero};

   wire zf_now = flags_r.zero_flag;
   wire cond_ok = !cond_op || (rep_ne ? !zf_now : zf_now);
   wire more = iterate_prefix && (cnt_r != 16'h0000) && cond_ok;
   // break between elements; intr and nmi break alike, neither is masked
   wire take_intr = i_intr_pending || i_nmi_pending;

   wire [15:0] addr_now = (state_r == SPS_RD_SRC) ? si_r : di_r;
   wire wr_now = (state_r == SPS_WRITE);
   assign buf_in_valid = (state_r == SPS_RD_SRC) || (state_r == SPS_RD_DST) || wr_now;
   // write data: moved element or accumulator
   wire [15:0] wdata_now = (op_r == sps_pkg::SPS_OP_MOVE) ? src_val_r : acc_r;
   assign buf_in_data = '{write: wr_now,
                          use_extra_seg: (state_r != SPS_RD_SRC),
                          seg_override: (state_r == SPS_RD_SRC) && ovr_r,
                          word: word_r,
                          offset: addr_now,
                          wdata: wdata_now};

   sps_buf u_buf (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_in_valid(buf_in_valid),
      .o_in_ready(buf_in_ready),
      .i_in_data(buf_in_data),
      .o_out_valid(o_mem_valid),
      .i_out_ready(i_mem_ready),
      .o_out_data(o_mem_req)
   );

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SPS_IDLE: if (i_start) state_nxt = SPS_CHECK;
         SPS_CHECK: begin
            if (iterate_prefix && cnt_r == 16'h0000) state_nxt = SPS_IDLE;
            else if (!first_r && take_intr) state_nxt = SPS_IDLE;
            else if (uses_src) state_nxt = SPS_RD_SRC;
            else if (reads_dst) state_nxt = SPS_RD_DST;
            else state_nxt = SPS_WRITE;
         end
         SPS_RD_SRC: if (buf_in_ready) state_nxt = SPS_WAIT_RD;
         SPS_RD_DST: if (buf_in_ready) state_nxt = SPS_WAIT_RD;
         SPS_WAIT_RD: begin
            if (i_rd_valid) begin
               if (waiting_dst_r || op_r == sps_pkg::SPS_OP_LOAD) state_nxt = SPS_NEXT;
               else if (op_r == sps_pkg::SPS_OP_COMPARE) state_nxt = SPS_RD_DST;
               else state_nxt = SPS_WRITE;
            end
         end
         SPS_WRITE: if (buf_in_ready) state_nxt = SPS_NEXT;
         SPS_NEXT: state_nxt = more ? SPS_CHECK : SPS_IDLE;
         default: state_nxt = SPS_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_r <= SPS_IDLE;
         prefix_r <= sps_pkg::SPS_PFX_NONE;
         op_r <= sps_pkg::SPS_OP_MOVE;
         word_r <= 1'b0;
         ovr_r <= 1'b0;
         dir_r <= 1'b0;
         si_r <= sps_pkg::SPS_RESET_WORD;
         di_r <= sps_pkg::SPS_RESET_WORD;
         cnt_r <= sps_pkg::SPS_RESET_WORD;
         acc_r <= sps_pkg::SPS_RESET_WORD;
         src_val_r <= sps_pkg::SPS_RESET_WORD;
         waiting_dst_r <= 1'b0;
         flags_r <= sps_pkg::SPS_FLAGS_RESET;
         done_r <= 1'b0;
         brk_r <= 1'b0;
         first_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         done_r <= 1'b0;
         brk_r <= 1'b0;
         if (state_r == SPS_IDLE && i_start) begin
            prefix_r <= i_prefix;
            op_r <= i_op;
            word_r <= i_word;
            ovr_r <= i_seg_override;
            dir_r <= i_direction_flag;
            si_r <= i_src_index;
            di_r <= i_dest_index;
            cnt_r <= i_repeat_count;
            acc_r <= i_accumulator;
            flags_r <= i_flags;
            first_r <= 1'b1;
         end
         if (state_r == SPS_CHECK) begin
            first_r <= 1'b0;
            // break leaves count and indices as updated
            if (iterate_prefix && cnt_r == 16'h0000) done_r <= 1'b1;
            else if (!first_r && take_intr) brk_r <= 1'b1;
         end
         if (state_r == SPS_RD_SRC || state_r == SPS_RD_DST) waiting_dst_r <= (state_r == SPS_RD_DST);
         if (state_r == SPS_WAIT_RD && i_rd_valid) begin
            if (!waiting_dst_r) src_val_r <= i_rd_data;
            // load into accumulator, high byte kept for bytes
            if (op_r == sps_pkg::SPS_OP_LOAD)
               acc_r <= word_r ? i_rd_data : {acc_r[15:8], i_rd_data[7:0]};
            if (waiting_dst_r) flags_r <= arith_flags;
         end
         if (state_r == SPS_NEXT) begin
            if (uses_src) si_r <= si_step;
            if (uses_dst) di_r <= di_step;
            if (iterate_prefix) cnt_r <= cnt_dec;
            if (!more) done_r <= 1'b1;
         end
      end
   end

   // count reaching zero after the last element is caught by the check state

   assign o_busy = (state_r != SPS_IDLE);
   assign o_done = done_r;
   assign o_intr_break = brk_r;
   // only the prefix just before the opcode survives resumption
   assign o_resume_prefix = prefix_r;
   assign o_src_index = si_r;
   assign o_dest_index = di_r;
   assign o_repeat_count = cnt_r;
   assign o_accumulator = acc_r;
   assign o_flags = flags_r;
endmodule : sps_sequencer

/* sps_assertions.sv */
// port assertions for the string primitive sequencer
`timescale 1ns/1ps
module sps_checker (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic [7:0] i_prefix,
   input wire sps_pkg::sps_op_t i_op,
   input wire logic i_word,
   input wire logic i_seg_override,
   input wire logic i_direction_flag,
   input wire logic [15:0] i_repeat_count,
   input wire logic i_mem_ready,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_intr_break,
   input wire logic [7:0] o_resume_prefix,
   input wire logic [15:0] o_dest_index,
   input wire logic [15:0] o_repeat_count,
   input wire sps_pkg::sps_flags_t o_flags,
   input wire logic o_mem_valid,
   input wire sps_pkg::sps_mem_req_t o_mem_req
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   wire rep_w = (i_prefix == sps_pkg::SPS_PFX_WHILE_EQUAL) || (i_prefix == sps_pkg::SPS_PFX_WHILE_UNEQUAL);
   wire [15:0] step_w = i_word ? sps_pkg::SPS_STEP_WORD : sps_pkg::SPS_STEP_BYTE;
   wire arith_w = (i_op == sps_pkg::SPS_OP_COMPARE) || (i_op == sps_pkg::SPS_OP_SCAN);
   // inputs are held by the driver for the whole instruction
   index_step_a: assert property ($past(o_busy) && o_busy && o_dest_index != $past(o_dest_index)
      |-> o_dest_index == $past(o_dest_index) + (i_direction_flag ? 16'h0000 - step_w : step_w))
      else $error("index step wrong");
   count_dec_a: assert property ($past(o_busy) && o_busy && o_repeat_count != $past(o_repeat_count)
      |-> o_repeat_count == $past(o_repeat_count) - 16'h0001) else $error("count step wrong");
   nopfx_count_a: assert property (o_busy && !rep_w |=> $stable(o_repeat_count))
      else $error("count moved without prefix");
   zero_count_a: assert property (i_start && !o_busy && rep_w && i_repeat_count == 16'h0000
      |=> !o_mem_valid ##1 (o_done && !o_mem_valid)) else $error("zero count not skipped");
   flags_kept_a: assert property (o_busy && !arith_w |=> $stable(o_flags))
      else $error("flags changed");
   dest_seg_a: assert property (o_mem_valid && o_mem_req.write |-> o_mem_req.use_extra_seg)
      else $error("write not in extra segment");
   src_seg_a: assert property (o_mem_valid && !o_mem_req.use_extra_seg
      |-> o_mem_req.seg_override == i_seg_override) else $error("source override wrong");
   req_hold_a: assert property (o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_req))
      else $error("request dropped");
   start_busy_a: assert property (i_start && !o_busy |=> o_busy) else $error("start not taken");
   resume_pfx_a: assert property (o_intr_break |-> !o_done && o_resume_prefix == i_prefix)
      else $error("resume prefix wrong");
   done_pulse_a: assert property (o_done |=> !o_done) else $error("done too long");
   cover property (o_done && rep_w);
   cover property (o_intr_break);
   cover property (o_mem_valid && !i_mem_ready);
endmodule : sps_checker
bind sps_sequencer sps_checker u_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
   .i_start(i_start), .i_prefix(i_prefix), .i_op(i_op), .i_word(i_word),
   .i_seg_override(i_seg_override), .i_direction_flag(i_direction_flag),
   .i_repeat_count(i_repeat_count), .i_mem_ready(i_mem_ready), .o_busy(o_busy),
   .o_done(o_done), .o_intr_break(o_intr_break), .o_resume_prefix(o_resume_prefix),
   .o_dest_index(o_dest_index), .o_repeat_count(o_repeat_count), .o_flags(o_flags),
   .o_mem_valid(o_mem_valid), .o_mem_req(o_mem_req));

/* sps_mem_model.sv */
// memory behind the bus interface: read data equals the offset
`timescale 1ns/1ps
module sps_mem_model (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_slow,
   input wire logic i_valid,
   input wire sps_pkg::sps_mem_req_t i_req,
   output logic o_ready,
   output logic o_rd_valid,
   output logic [15:0] o_rd_data,
   output logic [31:0] o_last_wr
);
   logic tick_r;
   logic [1:0] wait_r;
   logic [15:0] addr_r;
   // slow mode stalls every other cycle so requests wait in the buffer
   assign o_ready = !i_slow || tick_r;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         tick_r <= 1'b0;
         wait_r <= 2'h0;
         o_rd_valid <= 1'b0;
         o_rd_data <= 16'h0000;
         o_last_wr <= 32'h0;
      end else begin
         tick_r <= !tick_r;
         o_rd_valid <= (wait_r == 2'h1);
         // outside a reply the data toggles, never holding a stale value
         o_rd_data <= (wait_r == 2'h1) ? addr_r : ~o_rd_data;
         if (wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
         end
         if (i_valid && o_ready && !i_req.write) begin
            wait_r <= i_slow ? 2'h3 : 2'h1;
            addr_r <= i_req.offset;
         end
         if (i_valid && o_ready && i_req.write) begin
            o_last_wr <= {i_req.offset, i_req.wdata};
         end
      end
   end
endmodule : sps_mem_model

/* test_string_primitive_sequencer.sv */
// self-checking bench for the string primitive sequencer
`timescale 1ns/1ps
module test_string_primitive_sequencer;
   typedef struct {
      sps_pkg::sps_op_t op;
      logic [7:0] pfx;
      logic w;
      logic df;
      logic [15:0] src, dst, cnt, acc, esrc, edst, ecnt, eacc;
      logic ezf;
   } sps_row_t;
   logic clk, rst_n, start, word, ovr, df, intr, nmi, busy, done, brk, mvalid, mready, rvalid, slow;
   logic [7:0] prefix, rpfx;
   logic [15:0] src, dst, cnt, acc, osrc, odst, ocnt, oacc, rdata;
   logic [31:0] last_wr;
   sps_pkg::sps_op_t op;
   sps_pkg::sps_flags_t flags, oflg;
   sps_pkg::sps_mem_req_t req;
   int n_fail = 0;
   int n_tests = 0;
   int i, j, k;
   sps_row_t r;
   sps_row_t rows[10] = '{
      '{sps_pkg::SPS_OP_MOVE, 8'h77, 0, 0, 16'h10, 16'h20, 16'h5, 16'h1234, 16'h11, 16'h21, 16'h5, 16'h1234, 1},
      '{sps_pkg::SPS_OP_MOVE, 8'hf3, 1, 1, 16'h64, 16'hc8, 16'h3, 16'h1234, 16'h5e, 16'hc2, 16'h0, 16'h1234, 1},
      '{sps_pkg::SPS_OP_LOAD, 8'h00, 1, 0, 16'h30, 16'h40, 16'h1, 16'h1234, 16'h32, 16'h40, 16'h1, 16'h30, 1},
      '{sps_pkg::SPS_OP_LOAD, 8'h00, 0, 1, 16'h31, 16'h40, 16'h1, 16'hab00, 16'h30, 16'h40, 16'h1, 16'hab31, 1},
      '{sps_pkg::SPS_OP_STORE, 8'hf3, 0, 0, 16'h5, 16'hffff, 16'h2, 16'ha5, 16'h5, 16'h1, 16'h0, 16'ha5, 1},
      '{sps_pkg::SPS_OP_SCAN, 8'hf2, 0, 0, 16'h0, 16'h0, 16'ha, 16'h3, 16'h0, 16'h4, 16'h6, 16'h3, 1},
      '{sps_pkg::SPS_OP_COMPARE, 8'hf3, 0, 0, 16'h8, 16'h8, 16'h3, 16'h0, 16'hb, 16'hb, 16'h0, 16'h0, 1},
      '{sps_pkg::SPS_OP_COMPARE, 8'hf3, 0, 0, 16'h8, 16'h9, 16'h3, 16'h0, 16'h9, 16'ha, 16'h2, 16'h0, 0},
      '{sps_pkg::SPS_OP_COMPARE, 8'hf2, 1, 0, 16'h10, 16'h20, 16'h2, 16'h0, 16'h14, 16'h24, 16'h0, 16'h0, 0},
      '{sps_pkg::SPS_OP_MOVE, 8'hf3, 0, 0, 16'h10, 16'h20, 16'h0, 16'h0, 16'h10, 16'h20, 16'h0, 16'h0, 1}};
   sps_sequencer u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_prefix(prefix),
      .i_op(op), .i_word(word), .i_seg_override(ovr), .i_direction_flag(df), .i_src_index(src),
      .i_dest_index(dst), .i_repeat_count(cnt), .i_accumulator(acc), .i_flags(flags),
      .i_intr_pending(intr), .i_nmi_pending(nmi), .o_busy(busy), .o_done(done), .o_intr_break(brk),
      .o_resume_prefix(rpfx), .o_src_index(osrc), .o_dest_index(odst), .o_repeat_count(ocnt),
      .o_accumulator(oacc), .o_flags(oflg), .o_mem_valid(mvalid), .i_mem_ready(mready),
      .o_mem_req(req), .i_rd_valid(rvalid), .i_rd_data(rdata));
   sps_mem_model u_mem (.i_core_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_valid(mvalid),
      .i_req(req), .o_ready(mready), .o_rd_valid(rvalid), .o_rd_data(rdata), .o_last_wr(last_wr));
   task automatic complete_run();
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic run(input sps_row_t x, input logic ip, input logic np);
      @(posedge clk);
      op <= x.op;
      {prefix, word, df, ovr} <= {x.pfx, x.w, x.df, x.pfx[0]};
      {src, dst, cnt, acc, intr, nmi, start} <= {x.src, x.dst, x.cnt, x.acc, ip, np, 1'b1};
      @(posedge clk);
      start <= 1'b0;
      #1;
      chk("busy", 16'h1, {15'h0, busy});
      for (i = 0; i < 2000 && !(done === 1'b1 || brk === 1'b1); i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 2000) begin
         n_fail++;
         complete_run();
      end
   endtask : run
   task automatic chk_row(input sps_row_t x);
      chk("done", 16'h1, {15'h0, done});
      chk("src", x.esrc, osrc);
      chk("dest", x.edst, odst);
      chk("count", x.ecnt, ocnt);
      chk("acc", x.eacc, oacc);
      chk("zero", {15'h0, x.ezf}, {15'h0, oflg.zero_flag});
      // posted writes may still sit in the buffer after done
      for (i = 0; i < 50 && mvalid !== 1'b0; i++) @(posedge clk);
      #1;
      if (x.op == sps_pkg::SPS_OP_STORE) chk("stored", x.acc & 16'hff, last_wr[15:0] & 16'hff);
   endtask : chk_row
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      {rst_n, start, word, ovr, df, intr, nmi, slow, prefix} = '0;
      op = sps_pkg::SPS_OP_MOVE;
      {src, dst, cnt, acc} = '0;
      flags = 6'h01;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("reset", 16'h0, {14'h0, busy, mvalid} | ocnt);
      for (k = 0; k < 20; k++) begin
         @(posedge clk) slow <= (k >= 10);
         run(rows[k % 10], 1'b0, 1'b0);
         chk_row(rows[k % 10]);
      end
      for (k = 0; k < 2; k++) begin
         r = rows[0];
         {r.pfx, r.cnt, r.esrc, r.edst, r.ecnt, r.eacc} = {8'hf3, 16'h4, 16'h14, 16'h24, 16'h0, 16'h1234};
         run(r, k == 0, k == 1);
         chk("break", 16'h1, {15'h0, brk});
         chk("resume count", 16'h3, ocnt);
         chk("resume src", 16'h11, osrc);
         chk("resume prefix", 16'hf3, {8'h0, rpfx});
         {r.src, r.dst, r.cnt} = {osrc, odst, ocnt};
         run(r, 1'b0, 1'b0);
         chk_row(r);
      end
      complete_run();
   end
endmodule : test_string_primitive_sequencer
